/* inc/edl_pkg.sv */
// package for the divider non-volatile loader
`default_nettype none
package edl_pkg;
   localparam int            EDL_DIV_W      = 11;
   localparam int            EDL_LOCK_BIT   = 7;
   localparam logic [7:0]    EDL_ERASED     = 8'hFF;
   localparam logic [7:0]    EDL_HIGH_MASK  = 8'h87;
   localparam logic [7:0]    EDL_LOW_MASK   = 8'hFF;
   localparam logic [7:0]    EDL_REG_RESET  = 8'h00;

   // program / erase request towards one shadow byte
   typedef struct packed {
      logic       prog;
      logic       erase;
      logic       sel_high;
      logic [7:0] data;
   } edl_nv_cmd_t;

   // software write towards the volatile registers
   typedef struct packed {
      logic       wr_high;
      logic       wr_low;
      logic [7:0] data;
   } edl_sw_wr_t;

   typedef struct packed {
      logic [7:0] divider_high_reg;
      logic [7:0] divider_low_reg;
      logic [7:0] divider_high_shadow;
      logic [7:0] divider_low_shadow;
      logic       locked;
      logic       core_ready;
      logic       nv_refused;
      logic       wr_refused;
   } edl_state_t;

   localparam edl_state_t EDL_STATE_INIT = '{
      divider_high_reg:    8'h00,
      divider_low_reg:     8'h00,
      divider_high_shadow: 8'hFF,
      divider_low_shadow:  8'hFF,
      locked:              1'b0,
      core_ready:          1'b0,
      nv_refused:          1'b0,
      wr_refused:          1'b0
   };
endpackage : edl_pkg
`default_nettype wire

/* rtl/edl_loader.sv */
// divider shadow bytes, reset-time load and permanent lock
`default_nettype none
module edl_loader #(
   parameter int DIV_W = edl_pkg::EDL_DIV_W
) (
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire edl_pkg::edl_nv_cmd_t nv_cmd,
   input  wire edl_pkg::edl_sw_wr_t  sw_wr,
   output logic [7:0]               divider_high_reg,
   output logic [7:0]               divider_low_reg,
   output logic [7:0]               divider_high_shadow,
   output logic [7:0]               divider_low_shadow,
   output logic                     divider_locked,
   output logic                     core_ready,
   output logic                     nv_refused,
   output logic                     wr_refused
);
   import edl_pkg::*;

   // only the eleven-bit register layout is served
   if (DIV_W != EDL_DIV_W) begin : g_bad_div_w
      $error("divisor width not supported by the byte layout");
   end

   edl_state_t state = EDL_STATE_INIT;
   edl_state_t next_state;
   logic       nv_ok;
   logic       nv_req;
   logic       wr_req;
   logic [7:0] nv_old;
   logic [7:0] nv_new;

   always_comb begin
      next_state = state;
      nv_req     = nv_cmd.prog | nv_cmd.erase;
      wr_req     = sw_wr.wr_high | sw_wr.wr_low;
      nv_ok      = ~state.locked;
      nv_old     = nv_cmd.sel_high ? state.divider_high_shadow : state.divider_low_shadow;
      if (nv_cmd.erase) begin
         nv_new = EDL_ERASED;
      end else begin
         nv_new = nv_old & nv_cmd.data;
      end
      next_state.nv_refused = 1'b0;
      next_state.wr_refused = 1'b0;
      if (!rst_b) begin
         next_state.divider_high_shadow = state.divider_high_shadow;
         next_state.divider_low_shadow  = state.divider_low_shadow;
         next_state.divider_high_reg = state.divider_high_shadow & EDL_HIGH_MASK;
         next_state.divider_low_reg  = state.divider_low_shadow & EDL_LOW_MASK;
         // zero shadow bit relocks each reset
         next_state.locked     = ~state.divider_high_shadow[EDL_LOCK_BIT];
         next_state.core_ready = 1'b0;
      end else begin
         next_state.core_ready = 1'b1;
         // program and erase blocked when locked
         if (nv_req && nv_ok) begin
            if (nv_cmd.sel_high) begin
               next_state.divider_high_shadow = nv_new;
            end else begin
               next_state.divider_low_shadow = nv_new;
            end
         end else if (nv_req) begin
            next_state.nv_refused = 1'b1;
         end
         // shadow changes do not touch volatile
         if (wr_req && state.locked) begin
            next_state.wr_refused = 1'b1;
         end else begin
            if (sw_wr.wr_high) begin
               next_state.divider_high_reg = sw_wr.data & EDL_HIGH_MASK;
               // zero lock-disable bit arms the lock
               next_state.locked = ~sw_wr.data[EDL_LOCK_BIT];
            end
            if (sw_wr.wr_low) begin
               next_state.divider_low_reg = sw_wr.data & EDL_LOW_MASK;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      state <= next_state;
   end

   assign divider_high_reg    = state.divider_high_reg;
   assign divider_low_reg     = state.divider_low_reg;
   assign divider_high_shadow = state.divider_high_shadow;
   assign divider_low_shadow  = state.divider_low_shadow;
   assign divider_locked      = state.locked;
   assign core_ready          = state.core_ready;
   assign nv_refused          = state.nv_refused;
   assign wr_refused          = state.wr_refused;

   default clocking cb @(posedge core_clk);
   endclocking

   chk_shadow_reset_keep: assert property (
      !rst_b |=> $stable(state.divider_high_shadow) && $stable(state.divider_low_shadow))
      else $error("shadow byte changed during reset");

   chk_copy_on_reset: assert property (
      !rst_b |=> state.divider_high_reg == ($past(state.divider_high_shadow) & EDL_HIGH_MASK)
                 && state.divider_low_reg == $past(state.divider_low_shadow))
      else $error("volatile registers not loaded from shadow");

   chk_prog_applies: assert property (
      disable iff (!rst_b)
      !state.locked && nv_cmd.prog && !nv_cmd.erase && nv_cmd.sel_high
      |=> state.divider_high_shadow == ($past(state.divider_high_shadow) & $past(nv_cmd.data)))
      else $error("unlocked program did not apply");

   chk_no_early_load: assert property (
      disable iff (!rst_b)
      !sw_wr.wr_high && !sw_wr.wr_low
      |=> $stable(state.divider_high_reg) && $stable(state.divider_low_reg))
      else $error("volatile registers changed without reset or write");

   chk_lock_sticky: assert property (
      !rst_b && !state.divider_high_shadow[EDL_LOCK_BIT] |=> state.locked && !divider_high_reg[EDL_LOCK_BIT])
      else $error("lock not re-armed at reset");

   chk_nv_blocked: assert property (
      disable iff (!rst_b)
      state.locked && (nv_cmd.prog || nv_cmd.erase)
      |=> $stable(state.divider_high_shadow) && $stable(state.divider_low_shadow) && nv_refused)
      else $error("locked shadow byte was modified");

   chk_sw_ignored: assert property (
      disable iff (!rst_b)
      state.locked && (sw_wr.wr_high || sw_wr.wr_low)
      |=> $stable(state.divider_high_reg) && $stable(state.divider_low_reg) && wr_refused)
      else $error("locked volatile register was written");

   chk_erase_ones: assert property (
      disable iff (!rst_b)
      !state.locked && nv_cmd.erase && !nv_cmd.sel_high |=> state.divider_low_shadow == EDL_ERASED)
      else $error("erase did not set all bits");

   chk_ready_after: assert property (
      !rst_b |=> !core_ready)
      else $error("processor released during reset");

   chk_ready_set: assert property (
      rst_b |=> core_ready)
      else $error("processor not released after reset");

   chk_sw_lock_arm: assert property (
      rst_b && !state.locked && sw_wr.wr_high && !sw_wr.data[EDL_LOCK_BIT]
      |=> state.locked)
      else $error("zero lock-disable write did not lock");

   chk_erase_high: assert property (
      rst_b && !state.locked && nv_cmd.erase && nv_cmd.sel_high
      |=> state.divider_high_shadow == EDL_ERASED)
      else $error("high erase did not set all bits");

   chk_prog_low: assert property (
      rst_b && !state.locked && nv_cmd.prog && !nv_cmd.erase && !nv_cmd.sel_high
      |=> state.divider_low_shadow == ($past(state.divider_low_shadow) & $past(nv_cmd.data)))
      else $error("unlocked low program did not apply");

   chk_nv_pulse_idle: assert property (
      !(rst_b && state.locked && (nv_cmd.prog || nv_cmd.erase)) |=> !nv_refused)
      else $error("program refusal without a locked request");

   chk_wr_pulse_idle: assert property (
      !(rst_b && state.locked && (sw_wr.wr_high || sw_wr.wr_low)) |=> !wr_refused)
      else $error("write refusal without a locked request");

   chk_sw_applies: assert property (
      rst_b && !state.locked && sw_wr.wr_low
      |=> state.divider_low_reg == $past(sw_wr.data))
      else $error("unlocked low write did not apply");

   chk_high_masked: assert property (
      (state.divider_high_reg & ~EDL_HIGH_MASK) == 8'h00)
      else $error("unused high register bits set");

   chk_reset_quiet: assert property (
      !rst_b |=> !nv_refused && !wr_refused)
      else $error("refusal pulse during reset");

   cov_lock_reset: cover property (!rst_b && !state.divider_high_shadow[EDL_LOCK_BIT]);
   cov_prog_low: cover property (rst_b && !state.locked && nv_cmd.prog && !nv_cmd.sel_high);
   cov_sw_refused: cover property (rst_b && state.locked && sw_wr.wr_low);
   cov_release: cover property ($rose(rst_b) ##1 core_ready);
   cov_sw_arm: cover property (rst_b && !state.locked && sw_wr.wr_high && !sw_wr.data[7]);
endmodule : edl_loader
`default_nettype wire

/* tb/tb_edl_loader.sv */
// self-checking bench for the divider shadow loader
`default_nettype none
module tb_edl_loader;
   timeunit 1ns;
   timeprecision 1ps;
   import edl_pkg::*;
   logic        core_clk  = 1'b0;
   logic        rst_b     = 1'b0;
   edl_nv_cmd_t nv_cmd    = '0;
   edl_sw_wr_t  sw_wr     = '0;
   logic [7:0]  hi_reg, lo_reg, hi_sh, lo_sh;
   logic        locked, ready, nv_ref, wr_ref;
   int          n_fail    = 0;
   int          tests_run = 0;
   int          cycles    = 0;
   edl_loader edl_loader_i (.core_clk(core_clk), .rst_b(rst_b), .nv_cmd(nv_cmd),
      .sw_wr(sw_wr), .divider_high_reg(hi_reg), .divider_low_reg(lo_reg),
      .divider_high_shadow(hi_sh), .divider_low_shadow(lo_sh),
      .divider_locked(locked), .core_ready(ready), .nv_refused(nv_ref),
      .wr_refused(wr_ref));
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   // run ceiling
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_fail = n_fail + 1;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc;
      @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic do_reset;
      rst_b = 1'b0;
      repeat (6) cyc();
      rst_b = 1'b1;
      chk({7'h00, ready}, 8'h00);
      cyc();
      chk({7'h00, ready}, 8'h01);
   endtask : do_reset
   task automatic nv(input logic e, input logic p, input logic h, input logic [7:0] d);
      nv_cmd = '{prog: p, erase: e, sel_high: h, data: d};
      cyc();
      nv_cmd = '0;
   endtask : nv
   task automatic sw(input logic h, input logic l, input logic [7:0] d);
      sw_wr = '{wr_high: h, wr_low: l, data: d};
      cyc();
      sw_wr = '0;
   endtask : sw
   // erased shadows load unlocked divisor
   task automatic t_reset_load;
      chk(hi_reg, 8'h87);
      chk(lo_reg, 8'hFF);
      chk(hi_sh, 8'hFF);
      chk({7'h00, locked}, 8'h00);
   endtask : t_reset_load
   // program now, load only at reset
   task automatic t_program_defer;
      nv(1'b0, 1'b1, 1'b0, 8'h55);
      chk(lo_sh, 8'h55);
      chk(lo_reg, 8'hFF);
      cyc();
      nv(1'b0, 1'b1, 1'b1, 8'h83);
      chk(hi_reg, 8'h87);
      do_reset();
      chk(hi_sh, 8'h83);
      chk(hi_reg, 8'h83);
      chk(lo_reg, 8'h55);
   endtask : t_program_defer
   // software write and erase while open
   task automatic t_sw_erase;
      sw(1'b0, 1'b1, 8'hAA);
      chk(lo_reg, 8'hAA);
      chk({7'h00, wr_ref}, 8'h00);
      nv(1'b1, 1'b1, 1'b0, 8'h00);
      chk(lo_sh, 8'hFF);
      chk({7'h00, nv_ref}, 8'h00);
      sw(1'b1, 1'b0, 8'h05);
      chk(hi_reg, 8'h05);
      chk({7'h00, locked}, 8'h01);
      cyc();
      sw(1'b0, 1'b1, 8'h11);
      chk({7'h00, wr_ref}, 8'h01);
      chk(lo_reg, 8'hAA);
      do_reset();
      chk({7'h00, locked}, 8'h00);
      chk(hi_reg, 8'h83);
      chk(lo_reg, 8'hFF);
   endtask : t_sw_erase
   // zero lock bit, reset, then erases and writes refused
   task automatic t_lock;
      nv(1'b0, 1'b1, 1'b1, 8'h7F);
      chk(hi_sh, 8'h03);
      chk({7'h00, locked}, 8'h00);
      do_reset();
      chk({7'h00, locked}, 8'h01);
      chk(hi_reg, 8'h03);
      nv(1'b1, 1'b0, 1'b0, 8'h00);
      chk({7'h00, nv_ref}, 8'h01);
      chk(lo_sh, 8'hFF);
      cyc();
      nv(1'b1, 1'b0, 1'b1, 8'h00);
      chk(hi_sh, 8'h03);
      chk({7'h00, nv_ref}, 8'h01);
      sw(1'b1, 1'b1, 8'h81);
      chk({7'h00, wr_ref}, 8'h01);
      chk(hi_reg, 8'h03);
      chk(lo_reg, 8'hFF);
      cyc();
      chk({7'h00, wr_ref}, 8'h00);
      do_reset();
      chk({7'h00, locked}, 8'h01);
      chk(hi_reg, 8'h03);
   endtask : t_lock
   initial begin
      do_reset();
      t_reset_load();
      t_program_defer();
      t_sw_erase();
      t_lock();
      wrap_up();
   end
endmodule : tb_edl_loader
`default_nettype wire
